// [logic/sfd_defines.svh]
// Register map, field positions, reset values and timing counts of the fault front end
`ifndef SFD_DEFINES_SVH
`define SFD_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SFD_CH_CFG_BASE 8'h00
`define SFD_THRESH_BASE 8'h20
`define SFD_DIN_CFG_BASE 8'h40
`define SFD_STATUS_OFS 8'h50
`define SFD_VIEW_SEL_OFS 8'h54
`define SFD_VIEW_OFS 8'h58

// ****************************************
// Field positions
// ****************************************
`define SFD_CFG_RANGE 1:0
`define SFD_CFG_MODE 3:2
`define SFD_CFG_GLITCH 10:4
`define SFD_CFG_HYST 15:11
`define SFD_THR_UV 7:0
`define SFD_THR_OV 15:8
`define SFD_DIN_DIGITAL 0
`define SFD_DIN_EDGE 1
`define SFD_DIN_PULLDOWN 2
`define SFD_DIN_WIDTH 9:3

// ****************************************
// Reset values
// ****************************************
`define SFD_CH_CFG_RST 16'h0008
`define SFD_THRESH_RST 16'hFF00
`define SFD_DIN_CFG_RST 10'h000
`define SFD_HYST_MAX 5'h1F

// ****************************************
// Timing
// ****************************************
`define SFD_CLK_HZ 20000000
`define SFD_MAX_TIME_US 100
`define SFD_TICKS_PER_US (`SFD_CLK_HZ / 1000000)
`define SFD_MAX_TICKS (`SFD_MAX_TIME_US * `SFD_TICKS_PER_US)

// ****************************************
// Range table, bottom and span in microvolts
// ****************************************
`define SFD_R0_BOT 573000
`define SFD_R0_SPAN 802000
`define SFD_R1_BOT 1250000
`define SFD_R1_SPAN 1750000
`define SFD_R2_BOT 2500000
`define SFD_R2_SPAN 3500000
`define SFD_R3_BOT 4800000
`define SFD_R3_SPAN 9600000
`define SFD_CODE_FULL 255

`endif

// [logic/sfd_pkg.sv]
// Types shared by the fault front end
`default_nettype none
package sfd_pkg;
  typedef enum logic [1:0] {
    SFD_MODE_UNDER,
    SFD_MODE_OVER,
    SFD_MODE_WINDOW
  } sfd_mode_t;

  typedef enum logic [1:0] {
    SFD_RANGE_LOW,
    SFD_RANGE_MID,
    SFD_RANGE_HIGH,
    SFD_RANGE_TOP
  } sfd_range_t;

  typedef enum logic [1:0] {
    SFD_RESP_OKAY = 2'h0,
    SFD_RESP_SLVERR = 2'h2
  } sfd_resp_t;
endpackage
`default_nettype wire

// [logic/sfd_frontend.sv]
// Digital back end of the eight channel supply fault detector front end
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`include "sfd_defines.svh"
`default_nettype none
module sfd_frontend
  import sfd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] cmp_under,
  input wire logic [7:0] cmp_over,
  input wire logic [3:0] dual_function_pin,
  output logic [7:0][7:0] under_ref_code,
  output logic [7:0][7:0] over_ref_code,
  output logic [7:0][1:0] range_sel,
  output logic [3:0] dual_to_dedicated,
  output logic [3:0] pulldown_en,
  output logic [7:0] supply_fault,
  output logic [3:0] warning,
  output logic warning_any,
  output logic [3:0] digital_input
);

  // ****************************************
  // Functions
  // ****************************************
  // Program time in us to clock ticks, saturated at the 100 us ceiling
  function automatic logic [11:0] us_to_ticks(input logic [6:0] us);
    logic [11:0] t;
    t = 12'(us) * 12'(`SFD_TICKS_PER_US);
    if (t > 12'(`SFD_MAX_TICKS)) begin
      t = 12'(`SFD_MAX_TICKS);
    end
    return t;
  endfunction
  // Clamp a requested range to what the channel can offer
  function automatic logic [1:0] legal_range(input int ch, input logic [1:0] req);
    logic [1:0] r;
    r = req;
    if (ch >= 4) begin
      r = 2'(SFD_RANGE_LOW);
    end else if (ch == 3) begin
      r = (req < 2'(SFD_RANGE_HIGH)) ? 2'(SFD_RANGE_HIGH) : req;
    end else if (req == 2'(SFD_RANGE_TOP)) begin
      r = 2'(SFD_RANGE_HIGH);
    end
    return r;
  endfunction
  // Threshold in microvolts for a range and code
  function automatic logic [31:0] thresh_uv(input logic [1:0] rng, input logic [7:0] code);
    logic [39:0] bot;
    logic [39:0] span;
    logic [39:0] v;
    unique case (rng)
      2'd0: begin bot = 40'(`SFD_R0_BOT); span = 40'(`SFD_R0_SPAN); end
      2'd1: begin bot = 40'(`SFD_R1_BOT); span = 40'(`SFD_R1_SPAN); end
      2'd2: begin bot = 40'(`SFD_R2_BOT); span = 40'(`SFD_R2_SPAN); end
      default: begin bot = 40'(`SFD_R3_BOT); span = 40'(`SFD_R3_SPAN); end
    endcase
    v = bot + (span * 40'(code)) / 40'(`SFD_CODE_FULL);
    return v[31:0];
  endfunction
  // Byte lane merge for AXI writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction
  // ****************************************
  // Register state
  // ****************************************
  logic [15:0] ch_cfg_q [8];
  logic [15:0] thresh_q [8];
  logic [9:0] din_cfg_q [4];
  logic [2:0] view_sel_q;
  logic [7:0] aw_addr_q;
  logic aw_full_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  // ****************************************
  // Write decode
  // ****************************************
  wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [2:0] w_ch = aw_addr_q[4:2];
  wire w_cfg = aw_addr_q[7:5] == 3'h0;
  wire w_thr = aw_addr_q[7:5] == 3'h1;
  wire w_din = aw_addr_q[7:4] == 4'h4;
  wire w_vsel = aw_addr_q[7:2] == `SFD_VIEW_SEL_OFS >> 2;
  wire w_ro = aw_addr_q[7:2] == `SFD_STATUS_OFS >> 2 || aw_addr_q[7:2] == `SFD_VIEW_OFS >> 2;
  wire w_hit = w_cfg || w_thr || w_din || w_vsel || w_ro;
  wire [31:0] cfg_new = merge({16'h0000, ch_cfg_q[w_ch]}, w_data_q, w_strb_q);
  wire [31:0] thr_new = merge({16'h0000, thresh_q[w_ch]}, w_data_q, w_strb_q);
  wire [31:0] din_new = merge({22'h000000, din_cfg_q[w_ch[1:0]]}, w_data_q, w_strb_q);
  wire [31:0] vsel_new = merge({29'h00000000, view_sel_q}, w_data_q, w_strb_q);
  // ****************************************
  // Write channel
  // ****************************************
  // One write in flight: both ready lines drop once their beat is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? 2'(SFD_RESP_OKAY) : 2'(SFD_RESP_SLVERR);
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        ch_cfg_q[i] <= `SFD_CH_CFG_RST;
        thresh_q[i] <= `SFD_THRESH_RST;
      end
      for (int i = 0; i < 4; i++) begin
        din_cfg_q[i] <= `SFD_DIN_CFG_RST;
      end
      view_sel_q <= 3'h0;
    end else if (do_write) begin
      if (w_cfg) begin
        ch_cfg_q[w_ch] <= {cfg_new[15:2], legal_range(int'(w_ch), cfg_new[1:0])};
      end
      if (w_thr) begin
        thresh_q[w_ch] <= thr_new[15:0];
      end
      if (w_din && !w_ch[2]) begin
        din_cfg_q[w_ch[1:0]] <= din_new[9:0];
      end
      if (w_vsel) begin
        view_sel_q <= vsel_new[2:0];
      end
    end
  end
  // ****************************************
  // Channel roles and ranges
  // ****************************************
  logic [3:0] is_digital;
  logic [1:0] eff_range [8];
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      is_digital[i] = din_cfg_q[i][`SFD_DIN_DIGITAL];
      eff_range[i] = ch_cfg_q[i][`SFD_CFG_RANGE];
      // Warning detector borrows the primary detector's range
      eff_range[4 + i] = is_digital[i] ? ch_cfg_q[i][`SFD_CFG_RANGE] : 2'(SFD_RANGE_LOW);
    end
  end
  // ****************************************
  // Comparator state and hysteresis
  // ****************************************
  // Comparators see the shifted reference, so their raw output is the fault state
  logic [7:0] under_q;
  logic [7:0] over_q;
  logic [7:0] raw_fault;
  logic [7:0][7:0] under_ref_d;
  logic [7:0][7:0] over_ref_d;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      logic [8:0] up;
      logic [4:0] hy;
      hy = ch_cfg_q[i][`SFD_CFG_HYST];
      up = 9'(thresh_q[i][`SFD_THR_UV]) + 9'(hy);
      under_ref_d[i] = thresh_q[i][`SFD_THR_UV];
      over_ref_d[i] = thresh_q[i][`SFD_THR_OV];
      if (under_q[i]) begin
        under_ref_d[i] = up[8] ? 8'hFF : up[7:0];
      end
      if (over_q[i]) begin
        over_ref_d[i] = (thresh_q[i][`SFD_THR_OV] > 8'(hy)) ?
                        thresh_q[i][`SFD_THR_OV] - 8'(hy) : 8'h00;
      end
      unique case (ch_cfg_q[i][`SFD_CFG_MODE])
        2'(SFD_MODE_UNDER): raw_fault[i] = under_q[i];
        2'(SFD_MODE_OVER): raw_fault[i] = over_q[i];
        default: raw_fault[i] = under_q[i] || over_q[i];
      endcase
    end
  end
  // ****************************************
  // Glitch filters, 8 detectors and 4 pins
  // ****************************************
  // A change must hold for the full timeout, so the output lags by the timeout
  logic [11:0] gf_in;
  logic [11:0] gf_out_q;
  logic [11:0] gf_cnt_q [12];
  logic [11:0] gf_ticks [12];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      gf_in[i] = raw_fault[i];
      gf_ticks[i] = us_to_ticks(ch_cfg_q[i][`SFD_CFG_GLITCH]);
    end
    for (int i = 0; i < 4; i++) begin
      gf_in[8 + i] = dual_function_pin[i];
      // Pins reuse their channel's filter setting
      gf_ticks[8 + i] = us_to_ticks(ch_cfg_q[4 + i][`SFD_CFG_GLITCH]);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      under_q <= 8'h00;
      over_q <= 8'h00;
      gf_out_q <= 12'h000;
      for (int i = 0; i < 12; i++) begin
        gf_cnt_q[i] <= 12'h000;
      end
    end else begin
      under_q <= cmp_under;
      over_q <= cmp_over;
      for (int i = 0; i < 12; i++) begin
        if (gf_in[i] == gf_out_q[i]) begin
          gf_cnt_q[i] <= 12'h000;
        end else if (gf_cnt_q[i] + 12'h001 >= gf_ticks[i]) begin
          gf_out_q[i] <= gf_in[i];
          gf_cnt_q[i] <= 12'h000;
        end else begin
          gf_cnt_q[i] <= gf_cnt_q[i] + 12'h001;
        end
      end
    end
  end
  // ****************************************
  // Digital input blocks
  // ****************************************
  logic [3:0] din_prev_q;
  logic [11:0] pulse_cnt_q [4];
  logic [3:0] din_d;
  logic [3:0] warn_d;
  logic [7:0] fault_d;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      din_d[i] = 1'b0;
      if (is_digital[i]) begin
        din_d[i] = din_cfg_q[i][`SFD_DIN_EDGE] ? (pulse_cnt_q[i] != 12'h000)
                                               : gf_out_q[8 + i];
      end
      fault_d[i] = gf_out_q[i];
      fault_d[4 + i] = !is_digital[i] && gf_out_q[4 + i];
      warn_d[i] = is_digital[i] && gf_out_q[4 + i];
    end
  end
  // A zero width still gives one clock so no edge goes unseen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_prev_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        pulse_cnt_q[i] <= 12'h000;
      end
    end else begin
      din_prev_q <= gf_out_q[11:8];
      for (int i = 0; i < 4; i++) begin
        if (gf_out_q[8 + i] != din_prev_q[i]) begin
          pulse_cnt_q[i] <= (din_cfg_q[i][`SFD_DIN_WIDTH] == 7'h00) ? 12'h001
                          : us_to_ticks(din_cfg_q[i][`SFD_DIN_WIDTH]);
        end else if (pulse_cnt_q[i] != 12'h000) begin
          pulse_cnt_q[i] <= pulse_cnt_q[i] - 12'h001;
        end
      end
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_fault <= 8'h00;
      warning <= 4'h0;
      warning_any <= 1'b0;
      digital_input <= 4'h0;
      pulldown_en <= 4'h0;
      dual_to_dedicated <= 4'h0;
      under_ref_code <= '0;
      over_ref_code <= '0;
      range_sel <= '0;
    end else begin
      supply_fault <= fault_d;
      warning <= warn_d;
      warning_any <= |warn_d;
      digital_input <= din_d;
      pulldown_en <= is_digital & {din_cfg_q[3][2], din_cfg_q[2][2],
                                   din_cfg_q[1][2], din_cfg_q[0][2]};
      dual_to_dedicated <= is_digital;
      under_ref_code <= under_ref_d;
      over_ref_code <= over_ref_d;
      for (int i = 0; i < 8; i++) begin
        range_sel[i] <= eff_range[i];
      end
    end
  end
  // ****************************************
  // Read channel
  // ****************************************
  wire [2:0] r_ch = s_axi_araddr[4:2];
  wire r_cfg = s_axi_araddr[7:5] == 3'h0;
  wire r_thr = s_axi_araddr[7:5] == 3'h1;
  wire r_din = s_axi_araddr[7:4] == 4'h4 && !r_ch[2];
  wire r_stat = s_axi_araddr[7:2] == `SFD_STATUS_OFS >> 2;
  wire r_vsel = s_axi_araddr[7:2] == `SFD_VIEW_SEL_OFS >> 2;
  wire r_view = s_axi_araddr[7:2] == `SFD_VIEW_OFS >> 2;
  wire r_hit = r_cfg || r_thr || r_din || r_stat || r_vsel || r_view;
  wire [31:0] view_val = thresh_uv(eff_range[view_sel_q], thresh_q[view_sel_q][`SFD_THR_UV]);
  wire [31:0] status_val = {15'h0000, warning_any, digital_input, warning, supply_fault};
  wire [31:0] rdata_d = r_cfg ? {16'h0000, ch_cfg_q[r_ch]} :
                        r_thr ? {16'h0000, thresh_q[r_ch]} :
                        r_din ? {22'h000000, din_cfg_q[r_ch[1:0]]} :
                        r_stat ? status_val :
                        r_vsel ? {29'h00000000, view_sel_q} :
                        r_view ? view_val : 32'h00000000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= r_hit ? 2'(SFD_RESP_OKAY) : 2'(SFD_RESP_SLVERR);
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// [dv/sfd_fe_asserts.sv]
// Port-level assertion checker for the fault front end
`default_nettype none
module sfd_fe_asserts
  import sfd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0][1:0] range_sel,
  input wire logic [3:0] dual_to_dedicated,
  input wire logic [3:0] pulldown_en,
  input wire logic [7:0] supply_fault,
  input wire logic [3:0] warning,
  input wire logic warning_any,
  input wire logic [3:0] digital_input
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************************************
  // Channel roles
  // ****************************************
  // Role masks use the previous cycle too, since outputs settle one edge after a role change
  a_warn_or_any: assert property ((warning != 4'h0) |-> ##[0:1] warning_any)
    else $error("warning_any did not follow warning");
  a_warn_any_cause: assert property (warning_any |-> (warning != 4'h0) || ($past(warning) != 4'h0))
    else $error("warning_any without a warning");
  a_dual_excl: assert property ((dual_to_dedicated & $past(dual_to_dedicated) & supply_fault[7:4]) == 4'h0)
    else $error("fault flagged on a digital channel");
  a_din_analog: assert property ((digital_input & ~dual_to_dedicated & ~$past(dual_to_dedicated)) == 4'h0)
    else $error("digital output on an analog channel");
  a_warn_role: assert property ((warning & ~dual_to_dedicated & ~$past(dual_to_dedicated)) == 4'h0)
    else $error("warning on an analog channel");
  a_pull_role: assert property ((pulldown_en & ~dual_to_dedicated & ~$past(dual_to_dedicated)) == 4'h0)
    else $error("pull-down on an analog channel");
  // A dual detector in the warning role borrows the range of its dedicated channel
  logic [3:0] rng_low_ok;
  logic [3:0] rng_warn_ok;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      rng_low_ok[i] = dual_to_dedicated[i] || range_sel[4 + i] == 2'h0;
      rng_warn_ok[i] = !dual_to_dedicated[i] || range_sel[4 + i] == range_sel[i];
    end
  end
  a_range_dual: assert property (rng_low_ok == 4'hF)
    else $error("dual channel left lowest range");
  a_range_warn: assert property (rng_warn_ok == 4'hF)
    else $error("warning detector range differs from its channel");
  a_range_pos: assert property (range_sel[0] != 2'h3 && range_sel[1] != 2'h3 && range_sel[2] != 2'h3)
    else $error("positive channel in top range");
  // ****************************************
  // Register bus
  // ****************************************
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_r_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule
bind sfd_frontend sfd_fe_asserts u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .range_sel, .dual_to_dedicated, .pulldown_en, .supply_fault,
  .warning, .warning_any, .digital_input);
`default_nettype wire

// [dv/sfd_seq_model.sv]
// Sequencing engine stand-in that counts rising input events
`default_nettype none
module sfd_seq_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] supply_fault,
  input wire logic [3:0] digital_input,
  output logic [11:0][7:0] ev_rise
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] ev_q;
  wire logic [11:0] ev_now = {digital_input, supply_fault};
  // Counting rises catches short pulses that a sampled check would miss
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_q <= '0;
      ev_rise <= '0;
    end else begin
      ev_q <= ev_now;
      for (int i = 0; i < 12; i++) begin
        if (ev_now[i] && !ev_q[i]) ev_rise[i] <= ev_rise[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench of the fault front end
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import sfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF, dual_function_pin = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, warning_any;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] cmp_under = 8'h00, cmp_over = 8'h00, supply_fault, r0;
  logic [7:0][7:0] under_ref_code, over_ref_code;
  logic [7:0][1:0] range_sel;
  logic [3:0] dual_to_dedicated, pulldown_en, warning, digital_input;
  logic [11:0][7:0] ev_rise;
  int err_total = 0;
  int total_checks = 0;
  initial begin
    forever #25 aclk = ~aclk;
  end
  sfd_frontend dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmp_under,
    .cmp_over, .dual_function_pin, .under_ref_code, .over_ref_code, .range_sel,
    .dual_to_dedicated, .pulldown_en, .supply_fault, .warning, .warning_any, .digital_input);
  sfd_seq_model seq (.aclk, .aresetn, .supply_fault, .digital_input, .ev_rise);
  // ****************************************
  // Bus and utility tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    `CHK(rsp, er)
    // One more edge so registered outputs show the write before callers look
    @(posedge aclk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK(rdat, e)
    `CHK(rsp, er)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    chk_rd(8'h00, 32'h0000_0008, SFD_RESP_OKAY);
    chk_rd(8'h20, 32'h0000_FF00, SFD_RESP_OKAY);
    chk_rd(8'h5C, 32'h0, SFD_RESP_SLVERR);
    wr(8'h7C, 32'h1, SFD_RESP_SLVERR);
    `CHK(over_ref_code[0], 8'hFF)
  endtask
  task automatic t_range();
    wr(8'h00, 32'h3, SFD_RESP_OKAY);
    `CHK(range_sel[0], 2'h2)
    wr(8'h0C, 32'h0, SFD_RESP_OKAY);
    `CHK(range_sel[3], 2'h2)
    wr(8'h10, 32'h2, SFD_RESP_OKAY);
    `CHK(range_sel[4], 2'h0)
    wr(8'h0C, 32'h3, SFD_RESP_OKAY);
    wr(8'h2C, 32'hFF33, SFD_RESP_OKAY);
    wr(8'h54, 32'h3, SFD_RESP_OKAY);
    chk_rd(8'h58, 32'h0066_8A00, SFD_RESP_OKAY);
    wr(8'h00, 32'h2, SFD_RESP_OKAY);
    wr(8'h20, 32'hB633, SFD_RESP_OKAY);
    wr(8'h54, 32'h0, SFD_RESP_OKAY);
    chk_rd(8'h58, 32'h0030_D400, SFD_RESP_OKAY);
    `CHK(under_ref_code[0], 8'h33)
    `CHK(over_ref_code[0], 8'hB6)
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {28'h0, 2'(m), 2'h2}, SFD_RESP_OKAY);
      cmp_under[0] <= 1'b1;
      cyc(10);
      `CHK(supply_fault[0], 1'(m != 1))
      cmp_under[0] <= 1'b0;
      cyc(10);
      cmp_over[0] <= 1'b1;
      cyc(10);
      `CHK(supply_fault[0], 1'(m != 0))
      cmp_over[0] <= 1'b0;
      cyc(10);
    end
  endtask
  task automatic t_filter();
    // Undervoltage, 1 us filter, largest hysteresis code
    wr(8'h00, 32'h0000_F812, SFD_RESP_OKAY);
    r0 = ev_rise[0];
    cmp_under[0] <= 1'b1;
    cyc(15);
    cmp_under[0] <= 1'b0;
    cyc(40);
    `CHK(ev_rise[0], r0)
    cmp_under[0] <= 1'b1;
    cyc(12);
    `CHK(supply_fault[0], 1'b0)
    cyc(20);
    `CHK(supply_fault[0], 1'b1)
    `CHK(under_ref_code[0], 8'h52)
    chk_rd(8'h50, 32'h0000_0001, SFD_RESP_OKAY);
    cmp_under[0] <= 1'b0;
    cyc(40);
    `CHK(supply_fault[0], 1'b0)
    `CHK(under_ref_code[0], 8'h33)
    cmp_over[0] <= 1'b1;
    cyc(3);
    `CHK(over_ref_code[0], 8'h97)
    cmp_over[0] <= 1'b0;
  endtask
  task automatic t_warn();
    wr(8'h10, 32'h0, SFD_RESP_OKAY);
    wr(8'h30, 32'hFF40, SFD_RESP_OKAY);
    wr(8'h40, 32'h5, SFD_RESP_OKAY);
    cyc(2);
    `CHK(dual_to_dedicated, 4'h1)
    `CHK(pulldown_en, 4'h1)
    `CHK(range_sel[4], 2'h2)
    cmp_under[4] <= 1'b1;
    cyc(10);
    `CHK(supply_fault[4], 1'b0)
    `CHK(warning, 4'h1)
    `CHK(warning_any, 1'b1)
    chk_rd(8'h50, 32'h0001_0100, SFD_RESP_OKAY);
    cmp_under[4] <= 1'b0;
    wr(8'h40, 32'h4, SFD_RESP_OKAY);
    cmp_under[4] <= 1'b1;
    cyc(10);
    `CHK(pulldown_en, 4'h0)
    `CHK(supply_fault[4], 1'b1)
    `CHK(warning, 4'h0)
    cmp_under[4] <= 1'b0;
    cyc(10);
  endtask
  task automatic t_din();
    int n;
    wr(8'h14, 32'h10, SFD_RESP_OKAY);
    wr(8'h44, 32'h1, SFD_RESP_OKAY);
    r0 = ev_rise[9];
    dual_function_pin[1] <= 1'b1;
    cyc(5);
    dual_function_pin[1] <= 1'b0;
    cyc(40);
    `CHK(ev_rise[9], r0)
    dual_function_pin[1] <= 1'b1;
    cyc(40);
    `CHK(digital_input[1], 1'b1)
    `CHK(ev_rise[9], r0 + 8'h01)
    dual_function_pin[1] <= 1'b0;
    cyc(40);
    `CHK(digital_input[1], 1'b0)
    // Edge mode with a 1 us pulse, checked on both edges
    wr(8'h44, 32'h0B, SFD_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      dual_function_pin[1] <= (k == 0);
      n = 0;
      repeat (80) begin
        @(posedge aclk);
        if (digital_input[1] === 1'b1) n++;
      end
      `CHK(n, 20)
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_range();
    t_modes();
    t_filter();
    t_warn();
    t_din();
    results();
  end
endmodule
`default_nettype wire
